// [core/tarsr_pkg.sv]
// Package: offsets, field positions, reset values and timing for the touch converter registers
package tarsr_pkg;

  // ==========================================================================
  // Register offsets (word addresses on the serial control port)
  // ==========================================================================
  localparam logic [5:0] TARSR_OFF_STATUS  = 6'h01;
  localparam logic [5:0] TARSR_OFF_RSVD2   = 6'h02;
  localparam logic [5:0] TARSR_OFF_REFCTL  = 6'h03;
  localparam logic [5:0] TARSR_OFF_SRESET  = 6'h04;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int TARSR_ST_AVAIL    = 11;
  localparam int TARSR_ST_P2       = 7;
  localparam int TARSR_ST_B1       = 6;
  localparam int TARSR_ST_B2       = 5;
  localparam int TARSR_ST_AUX      = 4;
  localparam int TARSR_ST_T1       = 2;
  localparam int TARSR_ST_T2       = 1;
  localparam int TARSR_RC_SRC      = 4;
  localparam int TARSR_RC_DLY_LO   = 2;
  localparam int TARSR_RC_PDN      = 1;
  localparam int TARSR_RC_LVL      = 0;

  // ==========================================================================
  // Reset values and key
  // ==========================================================================
  localparam logic [15:0] TARSR_RSVD2_RST  = 16'hFFFF;
  localparam logic [15:0] TARSR_SRESET_RST = 16'hFFFF;
  localparam logic [15:0] TARSR_RESET_KEY  = 16'hBB00;
  localparam logic        TARSR_SRC_RST    = 1'b0;
  localparam logic [1:0]  TARSR_DLY_RST    = 2'b00;
  localparam logic        TARSR_PDN_RST    = 1'b1;
  localparam logic        TARSR_LVL_RST    = 1'b0;

  // Result channel indices in the ready vector
  localparam int TARSR_NCH   = 6;
  localparam int TARSR_CH_P2 = 0;
  localparam int TARSR_CH_B1 = 1;
  localparam int TARSR_CH_B2 = 2;
  localparam int TARSR_CH_AX = 3;
  localparam int TARSR_CH_T1 = 4;
  localparam int TARSR_CH_T2 = 5;

  // ==========================================================================
  // Settling times
  // ==========================================================================
  localparam int TARSR_CLK_MHZ     = 250;
  localparam int TARSR_DLY1_US     = 100;
  localparam int TARSR_DLY2_US     = 500;
  localparam int TARSR_DLY3_US     = 1000;
  localparam int TARSR_DLY1_CYC    = TARSR_DLY1_US * TARSR_CLK_MHZ;
  localparam int TARSR_DLY2_CYC    = TARSR_DLY2_US * TARSR_CLK_MHZ;
  localparam int TARSR_DLY3_CYC    = TARSR_DLY3_US * TARSR_CLK_MHZ;

  // Settling sequencer states
  typedef enum logic [1:0] {
    TARSR_IDLE   = 2'b00,
    TARSR_SETTLE = 2'b01,
    TARSR_READY  = 2'b10
  } tarsr_state_t;

endpackage : tarsr_pkg

// [core/tarsr_flag_if.sv]
// Interface: one result channel's store and read-done events plus its ready flag
`timescale 1ns/1ns
interface tarsr_flag_if;
  logic store;
  logic read_done;
  logic clear_all;
  logic ready;
  modport owner (input store, input read_done, input clear_all, output ready);
  modport user  (output store, output read_done, output clear_all, input ready);
endinterface : tarsr_flag_if

// [core/tarsr_flag.sv]
// Module: one sticky new-data flag, set on store, cleared after full read-out
`timescale 1ns/1ns
module tarsr_flag
  import tarsr_pkg::*;
(
  input  wire logic   clk,
  input  wire logic   nrst,
  tarsr_flag_if.owner f
);

  logic ready_q;

  // ==========================================================================
  // Flag register
  // ==========================================================================
  // Store wins over a read-done in the same cycle, so a fresh result is never lost
  always_ff @(posedge clk)
  begin
    if (!nrst || f.clear_all)
      ready_q <= 1'b0;
    else if (f.store)
      ready_q <= 1'b1;
    else if (f.read_done)
      ready_q <= 1'b0;
  end

  assign f.ready = ready_q;

endmodule : tarsr_flag

// [core/tarsr_top.sv]
// Top: status flags, reference control and keyed soft reset of the touch converter
`timescale 1ns/1ns
module tarsr_top
  import tarsr_pkg::*;
#(
  parameter int DLY1_CYC = TARSR_DLY1_CYC,
  parameter int DLY2_CYC = TARSR_DLY2_CYC,
  parameter int DLY3_CYC = TARSR_DLY3_CYC
)(
  input  wire logic        CLK,
  input  wire logic        NRST,
  input  wire logic        WR_EN,
  input  wire logic        RD_EN,
  input  wire logic [5:0]  ADDR,
  input  wire logic [15:0] WDATA,
  output logic      [15:0] RDATA,
  input  wire logic [5:0]  RESULT_STORE,
  input  wire logic [5:0]  RESULT_READ_DONE,
  input  wire logic        SET_DONE,
  input  wire logic        OTHER_PENDING,
  input  wire logic        CONV_REQ,
  output logic             CONV_GO,
  output logic             REF_INT_ON,
  output logic             REF_SRC_INT,
  output logic             REF_LVL_HIGH,
  output logic             SOFT_RESET
);

  logic         soft_rst;
  logic         src_q;
  logic [1:0]   dly_q;
  logic         pdn_q;
  logic         lvl_q;
  logic         avail_q;
  logic [5:0]   ready;
  logic         soft_rst_q;
  tarsr_state_t state_q;
  logic [31:0]  cnt_q;
  logic [31:0]  wait_cyc;
  logic         need_wait;

  // ==========================================================================
  // Keyed soft reset
  // ==========================================================================
  // Only the exact key resets; anything else is dropped and the register keeps
  // reading its default, since the key register itself stores nothing useful
  assign soft_rst = WR_EN && (ADDR == TARSR_OFF_SRESET)
                    && (WDATA == TARSR_RESET_KEY);

  // One-cycle pulse marking the soft reset
  always_ff @(posedge CLK)
  begin
    if (!NRST)
      soft_rst_q <= 1'b0;
    else
      soft_rst_q <= soft_rst;
  end

  assign SOFT_RESET = soft_rst_q;

  // ==========================================================================
  // Per-channel ready flags
  // ==========================================================================
  genvar gi;
  generate
    for (gi = 0; gi < TARSR_NCH; gi++)
    begin : g_flag
      tarsr_flag_if fi ();
      assign fi.store     = RESULT_STORE[gi];
      assign fi.read_done = RESULT_READ_DONE[gi];
      assign fi.clear_all = soft_rst;
      assign ready[gi]    = fi.ready;
      tarsr_flag tarsr_flag_inst (
        .clk  (CLK),
        .nrst (NRST),
        .f    (fi)
      );
    end
  endgenerate

  // ==========================================================================
  // Overall data-available bit
  // ==========================================================================
  // Held until every flag, including those kept outside this block, is clear
  always_ff @(posedge CLK)
  begin
    if (!NRST || soft_rst)
      avail_q <= 1'b0;
    else if (SET_DONE)
      avail_q <= 1'b1;
    else if ((ready == 6'h00) && !OTHER_PENDING)
      avail_q <= 1'b0;
  end

  // ==========================================================================
  // Reference control register
  // ==========================================================================
  // Only bits 4..0 are writable; upper bits are reserved and ignored
  always_ff @(posedge CLK)
  begin
    if (!NRST || soft_rst)
    begin
      src_q <= TARSR_SRC_RST;
      dly_q <= TARSR_DLY_RST;
      pdn_q <= TARSR_PDN_RST;
      lvl_q <= TARSR_LVL_RST;
    end
    else if (WR_EN && (ADDR == TARSR_OFF_REFCTL))
    begin
      src_q <= WDATA[TARSR_RC_SRC];
      dly_q <= WDATA[TARSR_RC_DLY_LO +: 2];
      pdn_q <= WDATA[TARSR_RC_PDN];
      lvl_q <= WDATA[TARSR_RC_LVL];
    end
  end

  assign REF_SRC_INT  = src_q;
  assign REF_LVL_HIGH = lvl_q;

  // ==========================================================================
  // Reference power and settling sequencer
  // ==========================================================================
  // Wait only when the reference is internal and cycled between conversions
  assign need_wait = src_q && pdn_q && (dly_q != 2'b00);

  always_comb
  begin
    case (dly_q)
      2'b01:   wait_cyc = 32'(DLY1_CYC);
      2'b10:   wait_cyc = 32'(DLY2_CYC);
      2'b11:   wait_cyc = 32'(DLY3_CYC);
      default: wait_cyc = 32'h0000_0000;
    endcase
  end

  // Request held by converter sequencer; go is granted after any settle wait
  always_ff @(posedge CLK)
  begin
    if (!NRST || soft_rst)
    begin
      state_q <= TARSR_IDLE;
      cnt_q   <= 32'h0000_0000;
    end
    else
    begin
      case (state_q)
        TARSR_IDLE:
        begin
          if (CONV_REQ && need_wait)
          begin
            state_q <= TARSR_SETTLE;
            cnt_q   <= wait_cyc - 32'h0000_0001;
          end
          else if (CONV_REQ)
            state_q <= TARSR_READY;
        end
        TARSR_SETTLE:
        begin
          if (!CONV_REQ)
            state_q <= TARSR_IDLE;
          else if (cnt_q == 32'h0000_0000)
            state_q <= TARSR_READY;
          else
            cnt_q <= cnt_q - 32'h0000_0001;
        end
        TARSR_READY:
        begin
          if (!CONV_REQ)
            state_q <= TARSR_IDLE;
        end
        default: state_q <= TARSR_IDLE;
      endcase
    end
  end

  assign CONV_GO = (state_q == TARSR_READY);

  // Internal reference: off in external mode, on always when not cycled
  assign REF_INT_ON = src_q && (!pdn_q || (state_q != TARSR_IDLE));

  // ==========================================================================
  // Read data
  // ==========================================================================
  // Registered so the serial port shifts a stable word
  always_ff @(posedge CLK)
  begin
    if (!NRST)
      RDATA <= 16'h0000;
    else if (RD_EN)
    begin
      case (ADDR)
        TARSR_OFF_STATUS:
        begin
          RDATA <= 16'h0000;
          RDATA[TARSR_ST_AVAIL] <= avail_q;
          RDATA[TARSR_ST_P2]    <= ready[TARSR_CH_P2];
          RDATA[TARSR_ST_B1]    <= ready[TARSR_CH_B1];
          RDATA[TARSR_ST_B2]    <= ready[TARSR_CH_B2];
          RDATA[TARSR_ST_AUX]   <= ready[TARSR_CH_AX];
          RDATA[TARSR_ST_T1]    <= ready[TARSR_CH_T1];
          RDATA[TARSR_ST_T2]    <= ready[TARSR_CH_T2];
        end
        TARSR_OFF_RSVD2:  RDATA <= TARSR_RSVD2_RST;
        TARSR_OFF_REFCTL: RDATA <= {11'h000, src_q, dly_q, pdn_q, lvl_q};
        TARSR_OFF_SRESET: RDATA <= TARSR_SRESET_RST;
        default:          RDATA <= 16'h0000;
      endcase
    end
  end

endmodule : tarsr_top

// [verification/tarsr_properties.sv]
// Checker: port-level properties of the register block
`timescale 1ns/1ns
module tarsr_properties
  import tarsr_pkg::*;
(
  input wire logic        CLK,
  input wire logic        NRST,
  input wire logic        WR_EN,
  input wire logic        RD_EN,
  input wire logic [5:0]  ADDR,
  input wire logic [15:0] WDATA,
  input wire logic [15:0] RDATA,
  input wire logic        CONV_REQ,
  input wire logic        CONV_GO,
  input wire logic        REF_INT_ON,
  input wire logic        REF_SRC_INT,
  input wire logic        REF_LVL_HIGH,
  input wire logic        SOFT_RESET
);
  // ====
  // Properties
  // ====
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);
  // Only the exact key may start a reset
  wire key_wr = WR_EN && ADDR == TARSR_OFF_SRESET && WDATA == TARSR_RESET_KEY;
  wire rc_wr  = WR_EN && ADDR == TARSR_OFF_REFCTL;
  a_key_pulse: assert property (key_wr |=> SOFT_RESET)
    else $error("no reset pulse after key");
  a_nonkey_quiet: assert property (!key_wr |=> !SOFT_RESET)
    else $error("reset pulse without key");
  a_reset_defaults: assert property (SOFT_RESET |-> !REF_SRC_INT && !REF_LVL_HIGH)
    else $error("reference bits not default after reset");
  a_ext_ref_off: assert property (!REF_SRC_INT |-> !REF_INT_ON)
    else $error("internal reference on in external mode");
  a_src_write: assert property (rc_wr |=> REF_SRC_INT == $past(WDATA[TARSR_RC_SRC]))
    else $error("source bit not written");
  a_lvl_write: assert property (rc_wr |=> REF_LVL_HIGH == $past(WDATA[TARSR_RC_LVL]))
    else $error("level bit not written");
  a_rsvd_read: assert property (RD_EN && ADDR == TARSR_OFF_RSVD2 |=> RDATA == 16'hFFFF)
    else $error("reserved word changed");
  a_key_reads: assert property (RD_EN && ADDR == TARSR_OFF_SRESET |=> RDATA == 16'hFFFF)
    else $error("reset word not default");
  a_refctl_upper: assert property (RD_EN && ADDR == TARSR_OFF_REFCTL |=> RDATA[15:5] == 11'h000)
    else $error("reserved reference bits set");
  a_status_rsvd: assert property (RD_EN && ADDR == TARSR_OFF_STATUS |=> !RDATA[3] && !RDATA[0])
    else $error("reserved status bits set");
  // Go is only ever granted against a request seen at the previous edge
  a_go_after_req: assert property (CONV_GO |-> $past(CONV_REQ))
    else $error("go without request");
  c_key: cover property (SOFT_RESET);
  c_go: cover property ($rose(CONV_GO));
  c_ref: cover property (REF_INT_ON && REF_SRC_INT);
endmodule : tarsr_properties

bind tarsr_top tarsr_properties tarsr_properties_inst (
  .CLK(CLK), .NRST(NRST), .WR_EN(WR_EN), .RD_EN(RD_EN), .ADDR(ADDR), .WDATA(WDATA),
  .RDATA(RDATA), .CONV_REQ(CONV_REQ), .CONV_GO(CONV_GO), .REF_INT_ON(REF_INT_ON),
  .REF_SRC_INT(REF_SRC_INT),
  .REF_LVL_HIGH(REF_LVL_HIGH), .SOFT_RESET(SOFT_RESET));

// [verification/tarsr_host.sv]
// Partner model: host on the register access port
`timescale 1ns/1ns
module tarsr_host
  import tarsr_pkg::*;
(
  input  wire logic        clk,
  input  wire logic [15:0] rdata,
  output logic             wr_en,
  output logic             rd_en,
  output logic      [5:0]  addr,
  output logic      [15:0] wdata
);
  // ====
  // Access tasks
  // ====
  // Idle port at time zero
  initial
  begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr  = 6'h00;
    wdata = 16'h0000;
  end
  // One-cycle write; data inverted after so stale values never pass
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr_en <= 1'b0;
    wdata <= ~d;
  endtask : wr
  // Word is registered at the request edge and taken one edge later,
  // where it stands until the next read
  task automatic rd(input logic [5:0] a, output logic [15:0] d);
    @(posedge clk);
    rd_en <= 1'b1;
    addr  <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask : rd
endmodule : tarsr_host

// [verification/tb_touch_adc_status_ref_reset.sv]
// Testbench: registers, result flags, settle timing, soft reset
`timescale 1ns/1ns
module tb_touch_adc_status_ref_reset import tarsr_pkg::*;;
  localparam int D1 = 4;
  localparam int D2 = 8;
  localparam int D3 = 12;
  localparam int POS [6] = '{7, 6, 5, 4, 2, 1};
  localparam logic [15:0] RC [6] = '{16'h0012, 16'h0016, 16'h001A, 16'h001E, 16'h001C, 16'h000E};
  localparam int WT [6] = '{1, D1 + 1, D2 + 1, D3 + 1, 1, 1};
  logic        clk, nrst, set_done, oth, conv_req, conv_go, ref_on, src, lvl, srst;
  logic        wr_en, rd_en;
  logic [5:0]  addr, store, rd_done;
  logic [15:0] wdata, rdata, got;
  int          mismatches, comparisons, n;
  // ====
  // Design, host and clock
  // ====
  tarsr_top #(.DLY1_CYC(D1), .DLY2_CYC(D2), .DLY3_CYC(D3)) tarsr_top_inst (
    .CLK(clk), .NRST(nrst), .WR_EN(wr_en), .RD_EN(rd_en), .ADDR(addr), .WDATA(wdata),
    .RDATA(rdata), .RESULT_STORE(store), .RESULT_READ_DONE(rd_done), .SET_DONE(set_done),
    .OTHER_PENDING(oth), .CONV_REQ(conv_req), .CONV_GO(conv_go), .REF_INT_ON(ref_on),
    .REF_SRC_INT(src), .REF_LVL_HIGH(lvl), .SOFT_RESET(srst));
  tarsr_host tarsr_host_inst (.clk(clk), .rdata(rdata), .wr_en(wr_en), .rd_en(rd_en),
    .addr(addr), .wdata(wdata));
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // ====
  // Helpers
  // ====
  task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic rd_chk(input logic [5:0] a, input logic [15:0] e);
    tarsr_host_inst.rd(a, got);
    chk($sformatf("reg%0h", a), e, got);
  endtask : rd_chk
  // One-cycle result events; pending level holds
  task automatic ev(input logic [5:0] s, input logic [5:0] r, input logic sd, input logic op);
    @(posedge clk);
    store    <= s;
    rd_done  <= r;
    set_done <= sd;
    oth      <= op;
    @(posedge clk);
    store    <= 6'h00;
    rd_done  <= 6'h00;
    set_done <= 1'b0;
  endtask : ev
  task automatic give_verdict();
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : give_verdict
  // ====
  // Sequence
  // ====
  initial
  begin
    {nrst, store, rd_done, set_done, oth, conv_req} = '0;
    mismatches = 0;
    comparisons = 0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    rd_chk(TARSR_OFF_REFCTL, 16'h0002);
    rd_chk(TARSR_OFF_STATUS, 16'h0000);
    rd_chk(TARSR_OFF_RSVD2, 16'hFFFF);
    rd_chk(TARSR_OFF_SRESET, 16'hFFFF);
    rd_chk(6'h3F, 16'h0000);
    $display("Test defaults done");
    // Each channel sets its own bit; last one keeps data-available up
    for (int i = 0; i < 6; i++)
    begin
      ev(6'h01 << i, 6'h00, 1'b1, i == 5);
      rd_chk(TARSR_OFF_STATUS, 16'h0800 | (16'h0001 << POS[i]));
      ev(6'h00, 6'h01 << i, 1'b0, i == 5);
      rd_chk(TARSR_OFF_STATUS, (i == 5) ? 16'h0800 : 16'h0000);
    end
    ev(6'h00, 6'h00, 1'b0, 1'b0);
    rd_chk(TARSR_OFF_STATUS, 16'h0000);
    ev(6'h01, 6'h01, 1'b0, 1'b0);
    rd_chk(TARSR_OFF_STATUS, 16'h0080);
    ev(6'h00, 6'h01, 1'b0, 1'b0);
    rd_chk(TARSR_OFF_STATUS, 16'h0000);
    $display("Test flags done");
    tarsr_host_inst.wr(TARSR_OFF_REFCTL, 16'hFFFF);
    rd_chk(TARSR_OFF_REFCTL, 16'h001F);
    chk("src", 16'h0001, {15'h0000, src});
    chk("lvl", 16'h0001, {15'h0000, lvl});
    tarsr_host_inst.wr(TARSR_OFF_SRESET, 16'h1234);
    @(posedge clk);
    chk("soft_reset", 16'h0000, {15'h0000, srst});
    rd_chk(TARSR_OFF_SRESET, 16'hFFFF);
    rd_chk(TARSR_OFF_REFCTL, 16'h001F);
    tarsr_host_inst.wr(TARSR_OFF_RSVD2, 16'h0000);
    rd_chk(TARSR_OFF_RSVD2, 16'hFFFF);
    tarsr_host_inst.wr(TARSR_OFF_STATUS, 16'hFFFF);
    rd_chk(TARSR_OFF_STATUS, 16'h0000);
    $display("Test refctl done");
    // Cycles from request to go, per delay code and mode; reference power is
    // looked at while go stands and again once the request has dropped
    for (int i = 0; i < 6; i++)
    begin
      tarsr_host_inst.wr(TARSR_OFF_REFCTL, RC[i]);
      @(posedge clk);
      conv_req <= 1'b1;
      n = 0;
      while (conv_go !== 1'b1 && n < 40)
      begin
        @(posedge clk);
        #1;
        n++;
      end
      // A hung sequencer counts as a mismatch and ends the settle loop; the later tests still run
      if (n >= 40)
      begin
        mismatches++;
        $display("Error go_wait expected %0d seen timeout", WT[i]);
        break;
      end
      chk("wait", WT[i][15:0], n[15:0]);
      chk("ref_on", {15'h0000, i != 5}, {15'h0000, ref_on});
      @(posedge clk);
      conv_req <= 1'b0;
      repeat (2) @(posedge clk);
      chk("ref_idle", {15'h0000, i == 4}, {15'h0000, ref_on});
    end
    $display("Test settle done");
    ev(6'h3F, 6'h00, 1'b1, 1'b0);
    tarsr_host_inst.wr(TARSR_OFF_REFCTL, 16'h001D);
    rd_chk(TARSR_OFF_STATUS, 16'h08F6);
    tarsr_host_inst.wr(TARSR_OFF_SRESET, TARSR_RESET_KEY);
    @(posedge clk);
    chk("soft_reset", 16'h0001, {15'h0000, srst});
    chk("src", 16'h0000, {15'h0000, src});
    chk("lvl", 16'h0000, {15'h0000, lvl});
    rd_chk(TARSR_OFF_REFCTL, 16'h0002);
    rd_chk(TARSR_OFF_STATUS, 16'h0000);
    $display("Test soft reset done");
    // Hardware reset in mid-run with a loaded register and a set flag
    tarsr_host_inst.wr(TARSR_OFF_REFCTL, 16'h0011);
    ev(6'h01, 6'h00, 1'b1, 1'b0);
    rd_chk(TARSR_OFF_STATUS, 16'h0880);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    rd_chk(TARSR_OFF_REFCTL, 16'h0002);
    rd_chk(TARSR_OFF_STATUS, 16'h0000);
    $display("Test hardware reset done");
    give_verdict();
  end
endmodule : tb_touch_adc_status_ref_reset
